// [common/tic_pkg.sv]
// package for the timer input-capture block: register map, field layout,
// reset values and mode codes.
// assumes a 32-bit axi4-lite register bus and one system clock.
package tic_pkg;

   // register byte offsets
   localparam logic [7:0] TIC_CTL0_OFF   = 8'h00;  // main control
   localparam logic [7:0] TIC_CTL1_OFF   = 8'h04;  // second control
   localparam logic [7:0] TIC_COUNT_OFF  = 8'h08;  // count value
   localparam logic [7:0] TIC_RELOAD_OFF = 8'h0C;  // reload value
   localparam logic [7:0] TIC_PWM_OFF    = 8'h10;  // pwm / capture value
   localparam logic [7:0] TIC_STAT_OFF   = 8'h14;  // sticky events
   localparam logic [7:0] TIC_MASK_OFF   = 8'h18;  // interrupt mask

   // control 0 fields
   localparam int TIC_EN_BIT    = 7;
   localparam int TIC_POL_BIT   = 6;
   localparam int TIC_PRES_LSB  = 3;   // prescale exponent, 3 bits
   localparam int TIC_MODE_LSB  = 0;   // mode low bits, 3 bits
   // control 1 fields
   localparam int TIC_MODEHI_BIT = 7;
   localparam int TIC_SRC_LSB    = 5;  // interrupt source select, 2 bits
   localparam int TIC_CAPF_BIT   = 0;  // capture event flag (read only)
   // status / mask fields
   localparam int TIC_ST_CAP_BIT = 0;
   localparam int TIC_ST_RLD_BIT = 1;

   // reset and restart values
   localparam logic [15:0] TIC_COUNT_RST  = 16'h0001;
   localparam logic [15:0] TIC_RELOAD_RST = 16'hFFFF;
   localparam logic [15:0] TIC_PWM_RST    = 16'h0000;
   localparam logic [15:0] TIC_RESTART    = 16'h0001;
   localparam logic [7:0]  TIC_CTL_RST    = 8'h00;
   localparam logic [1:0]  TIC_SR_RST     = 2'h0;

   // axi responses
   localparam logic [1:0] TIC_RESP_OK  = 2'h0;
   localparam logic [1:0] TIC_RESP_ERR = 2'h2;

   // mode code: {mode_upper_bit, mode low bits}
   typedef enum logic [3:0] {
      TIC_M_CAPTURE  = 4'h4,
      TIC_M_CAPRST   = 4'hE,
      TIC_M_PWM      = 4'h3
   } tic_mode_t;

   // interrupt source select
   typedef enum logic [1:0] {
      TIC_SRC_BOTH   = 2'h0,
      TIC_SRC_BOTH2  = 2'h1,
      TIC_SRC_RELOAD = 2'h2,
      TIC_SRC_CAP    = 2'h3
   } tic_src_t;

   // event pair carried from the counter core
   typedef struct packed {
      logic cap;
      logic rld;
   } tic_evt_t;

endpackage : tic_pkg

// [core/tic_sync.sv]
// two-flop synchroniser with edge detection for the timer input pin.
// assumes the pin is asynchronous to mclk.
`timescale 1ns/1ps
module tic_sync
   import tic_pkg::*;
(
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // synchroniser chain; s1 feeds only s2
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // one pulse per transition of the synchronised level
   assign rise = s2_reg & ~s3_reg;
   assign fall = ~s2_reg & s3_reg;
endmodule : tic_sync

// [core/tic_timer.sv]
// 16-bit timer with capture, capture-restart and pwm modes behind an
// axi4-lite slave.
// assumes one 20 MHz clock, synchronous reset, timer input pin async.
// with polarity 1 the pwm output stays high for counts up to and including the pwm value.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

// Behaviour
// - in capture mode the chosen edge copies the count into the pwm value.
// - the polarity bit picks rising or falling edge for capture.
// - in capture mode a capture raises the interrupt and counting goes on.
// - every capture sets the capture event flag in the second control reg.
// - in capture mode reaching reload raises the interrupt and counting goes on.
// - in capture mode a reload interrupt clears the capture event flag.
// - in capture-restart a capture stores, interrupts and restarts at 0001H.
// - in capture-restart reaching reload interrupts and restarts at 0001H.
// - in capture-restart a reload interrupt clears the capture event flag.
// - the source select limits the interrupt to capture, reload, or both.
// - the count advances once per prescale system clocks.
// - in pwm mode with polarity 1 high time over period is pwm over reload.
module tic_timer
   import tic_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic        timer_in,
   output logic             timer_out,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0]  ctl0_reg;
   logic        modehi_reg;
   logic [1:0]  src_reg;
   logic        capf_reg;
   logic [15:0] count_reg;
   logic [15:0] reload_reg;
   logic [15:0] pwm_reg;
   logic [6:0]  pres_cnt_reg;
   logic [1:0]  stat_reg;
   logic [1:0]  mask_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        aw_have_reg;
   logic        w_have_reg;

   logic        rise;
   logic        fall;
   logic        edge_hit;
   logic        tick;
   logic        at_reload;
   logic        enabled;
   tic_mode_t   mode;
   tic_evt_t    evt;
   tic_evt_t    irq_evt;
   logic        wr_go;
   logic        rd_go;
   logic [6:0]  pres_max;
   logic        pwm_hi;

   ////////////////////////////////////////////////////////////////////////
   // input edge detection
   tic_sync u_sync (
      .mclk  (mclk),
      .reset (reset),
      .pin   (timer_in),
      .rise  (rise),
      .fall  (fall)
   );

   // polarity picks the capture edge
   assign edge_hit = ctl0_reg[TIC_POL_BIT] ? rise : fall;
   assign enabled  = ctl0_reg[TIC_EN_BIT];
   assign mode     = tic_mode_t'({modehi_reg,
                                  ctl0_reg[TIC_MODE_LSB +: 3]});

   // prescale is 2**exponent system clocks per count
   assign pres_max = 7'((8'h01 << ctl0_reg[TIC_PRES_LSB +: 3]) - 8'h01);
   assign tick      = enabled && (pres_cnt_reg == pres_max);
   assign at_reload = tick && (count_reg == reload_reg);

   // inclusive compare gives pwm high counts out of reload per period
   assign pwm_hi    = (count_reg <= pwm_reg);

   // events of the current cycle
   always_comb begin
      evt.cap = 1'b0;
      evt.rld = 1'b0;
      if (enabled) begin
         unique case (mode)
            TIC_M_CAPTURE, TIC_M_CAPRST: begin
               evt.cap = edge_hit;
               evt.rld = at_reload && !edge_hit;
            end
            TIC_M_PWM: evt.rld = at_reload;
            default: ;
         endcase
      end
   end

   // source select gates which events reach the interrupt
   always_comb begin
      irq_evt = evt;
      if (src_reg == TIC_SRC_CAP)
         irq_evt.rld = 1'b0;
      else if (src_reg == TIC_SRC_RELOAD)
         irq_evt.cap = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // axi handshake qualifiers
   assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   // prescaler
   // held at zero while disabled, so the first count comes a full period on
   always_ff @(posedge mclk) begin
      if (reset || !enabled || tick)
         pres_cnt_reg <= 7'h00;
      else
         pres_cnt_reg <= pres_cnt_reg + 7'h01;
   end

   // counter: capture-restart and reload restart at 0001H, capture runs on
   // a capture in the same tick as reload wins, so one event per tick
   always_ff @(posedge mclk) begin
      if (reset) begin
         count_reg <= TIC_COUNT_RST;
      end else if (wr_go && awaddr_reg == TIC_COUNT_OFF) begin
         count_reg <= wdata_reg[15:0];
      end else if (mode == TIC_M_CAPRST && evt.cap) begin
         count_reg <= TIC_RESTART;
      end else if (at_reload && mode != TIC_M_CAPTURE) begin
         count_reg <= TIC_RESTART;
      end else if (tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // pwm value: written by software, loaded by a capture
   always_ff @(posedge mclk) begin
      if (reset) begin
         pwm_reg <= TIC_PWM_RST;
      end else if (evt.cap) begin
         pwm_reg <= count_reg;
      end else if (wr_go && awaddr_reg == TIC_PWM_OFF) begin
         pwm_reg <= wdata_reg[15:0];
      end
   end

   // capture event flag: set on capture, cleared on a reload event
   always_ff @(posedge mclk) begin
      if (reset)
         capf_reg <= 1'b0;
      else if (evt.cap)
         capf_reg <= 1'b1;
      else if (evt.rld)
         capf_reg <= 1'b0;
   end

   // pwm output: high while count is up to pwm value when polarity is 1
   always_ff @(posedge mclk) begin
      if (reset)
         timer_out <= 1'b0;
      else if (enabled && mode == TIC_M_PWM)
         timer_out <= ~(pwm_hi ^ ctl0_reg[TIC_POL_BIT]);
      else
         timer_out <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // control, reload and mask registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctl0_reg   <= TIC_CTL_RST;
         modehi_reg <= 1'b0;
         src_reg    <= TIC_SR_RST;
         reload_reg <= TIC_RELOAD_RST;
         mask_reg   <= TIC_SR_RST;
      end else if (wr_go) begin
         unique case (awaddr_reg)
            TIC_CTL0_OFF: if (wstrb_reg[0]) ctl0_reg <= wdata_reg[7:0];
            TIC_CTL1_OFF: if (wstrb_reg[0]) begin
               modehi_reg <= wdata_reg[TIC_MODEHI_BIT];
               src_reg    <= wdata_reg[TIC_SRC_LSB +: 2];
            end
            TIC_RELOAD_OFF: reload_reg <= wdata_reg[15:0];
            TIC_MASK_OFF: if (wstrb_reg[0]) mask_reg <= wdata_reg[1:0];
            default: ;
         endcase
      end
   end

   // sticky status: events set, reading clears, set wins over clear
   // any byte address of the status word counts as a read of it
   always_ff @(posedge mclk) begin
      if (reset)
         stat_reg <= TIC_SR_RST;
      else if (rd_go && {s_axi_araddr[7:2], 2'b00} == TIC_STAT_OFF)
         stat_reg <= {irq_evt.rld, irq_evt.cap};
      else
         stat_reg <= stat_reg | {irq_evt.rld, irq_evt.cap};
   end

   // level interrupt
   always_ff @(posedge mclk) begin
      if (reset)
         irq <= 1'b0;
      else
         irq <= |(stat_reg & mask_reg);
   end

   ////////////////////////////////////////////////////////////////////////
   // write channel: address and data in either order
   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h00000000;
         wstrb_reg     <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= TIC_RESP_OK;
      end else begin
         s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            awaddr_reg  <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_reg <= TIC_MASK_OFF) ?
                            TIC_RESP_OK : TIC_RESP_ERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one cycle after address acceptance
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= TIC_RESP_OK;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= TIC_RESP_OK;
            s_axi_rdata  <= 32'h00000000;
            unique case ({s_axi_araddr[7:2], 2'b00})
               TIC_CTL0_OFF:   s_axi_rdata[7:0] <= ctl0_reg;
               TIC_CTL1_OFF:   s_axi_rdata[7:0] <= {modehi_reg, src_reg,
                                                    4'h0, capf_reg};
               TIC_COUNT_OFF:  s_axi_rdata[15:0] <= count_reg;
               TIC_RELOAD_OFF: s_axi_rdata[15:0] <= reload_reg;
               TIC_PWM_OFF:    s_axi_rdata[15:0] <= pwm_reg;
               TIC_STAT_OFF:   s_axi_rdata[1:0] <= stat_reg;
               TIC_MASK_OFF:   s_axi_rdata[1:0] <= mask_reg;
               default:        s_axi_rresp <= TIC_RESP_ERR;
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : tic_timer

// [test/tic_timer_asserts.sv]
// checker for the timer block: bus answers, masking and capture irq.
// assumes it is bound into tic_timer and sees only its ports.
`timescale 1ns/1ps
module tic_timer_chk
   import tic_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic        timer_in,
   input wire logic        timer_out,
   input wire logic        irq,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [7:0] aw_q, wd_q, c0_q, c1_q, mk_q;
   logic       b_q;
   logic       arm;
   ////////////////////////////////////////////////////////////////////////
   // shadow of control and mask writes, applied when the write answers
   always_ff @(posedge mclk) begin
      if (reset) begin
         {aw_q, wd_q, c0_q, c1_q, mk_q, b_q} <= '0;
      end else begin
         b_q <= s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[7:0];
         if (s_axi_bvalid && !b_q && aw_q == TIC_CTL0_OFF) c0_q <= wd_q;
         if (s_axi_bvalid && !b_q && aw_q == TIC_CTL1_OFF) c1_q <= wd_q;
         if (s_axi_bvalid && !b_q && aw_q == TIC_MASK_OFF) mk_q <= wd_q;
      end
   end
   // armed for a rising-edge capture that may interrupt
   assign arm = c0_q[7] && c0_q[6] && mk_q[0] && c1_q[6:5] != 2'h2 &&
                ({c1_q[7], c0_q[2:0]} == TIC_M_CAPTURE ||
                 {c1_q[7], c0_q[2:0]} == TIC_M_CAPRST);
   ////////////////////////////////////////////////////////////////////////
   sequence s_cap_edge;
      arm && !irq && $rose(timer_in) ##1 $stable(timer_in)[*4];
   endsequence
   sequence s_bad_ar;
      s_axi_arvalid && s_axi_arready &&
         {s_axi_araddr[7:2], 2'b00} > TIC_MASK_OFF;
   endsequence
   property p_cap_irq;
      s_cap_edge |-> ##[0:4] irq;
   endproperty
   property p_bad_rd;
      s_bad_ar |-> ##[1:3] (s_axi_rvalid && s_axi_rresp == TIC_RESP_ERR &&
                            s_axi_rdata == 32'h0);
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_no_ar;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_no_aw;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_irq_mask;
      mk_q == 8'h0 && !s_axi_bvalid && !b_q |-> !irq;
   endproperty
   property p_pwm_off;
      {c1_q[7], c0_q[2:0]} != TIC_M_PWM && !s_axi_bvalid && !b_q
         |-> !timer_out;
   endproperty
   property p_rst_quiet;
      $fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !timer_out;
   endproperty
   a_cap_irq: assert property (p_cap_irq)
      else $error("capture edge gave no interrupt");
   a_bad_rd: assert property (p_bad_rd)
      else $error("unmapped read not refused");
   a_b_hold: assert property (p_b_hold)
      else $error("write answer dropped early");
   a_r_hold: assert property (p_r_hold)
      else $error("read answer dropped or changed");
   a_no_ar: assert property (p_no_ar)
      else $error("read taken while answer pending");
   a_no_aw: assert property (p_no_aw)
      else $error("write taken while answer pending");
   a_irq_mask: assert property (p_irq_mask)
      else $error("interrupt with all events masked");
   a_pwm_off: assert property (p_pwm_off)
      else $error("timer output high outside pwm mode");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
endmodule : tic_timer_chk

bind tic_timer tic_timer_chk u_chk (.*);

// [test/tic_pin_src.sv]
// model of the external source on the timer input pin.
// assumes the bench sets the wanted level just after a clock edge.
`timescale 1ns/1ps
module tic_pin_src #(
   parameter time SKEW = 7
) (
   input  wire logic want,
   output logic      pin
);
   // pin follows the wanted level, skewed off the clock edge
   initial pin = 1'h0;
   always @(want) pin <= #SKEW want;
endmodule : tic_pin_src

// [test/tb_top.sv]
// self-checking bench for the timer block over its register bus.
// assumes the checker is bound in and the pin model drives timer_in.
`timescale 1ns/1ps
module tb_top
   import tic_pkg::*;
;
   logic        mclk = 1'h0, reset = 1'h1, want = 1'h0;
   logic        timer_in, timer_out, irq;
   logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rr;
   logic [31:0] rdata, rd;
   int          errors = 0, comparisons = 0, cyc = 0, t_ar = 0;
   tic_timer uut (.mclk(mclk), .reset(reset), .timer_in(timer_in),
      .timer_out(timer_out), .irq(irq), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   tic_pin_src u_pin (.want(want), .pin(timer_in));
   // clock and cycle count
   always #25 mclk = ~mclk;
   always @(posedge mclk) cyc <= cyc + 1;
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic hang;
      errors++;
      wrap_up();
   endtask : hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      {awaddr, wdata} <= {a, d};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n < 40 && bvalid !== 1'h1; n++) begin
         @(posedge mclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end
      bready <= 1'h0;
      if (n == 40) hang();
   endtask : wr
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge mclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n < 40 && rvalid !== 1'h1; n++) begin
         @(posedge mclk);
         if (arready && arvalid) t_ar = cyc;
         if (arready) arvalid <= 1'h0;
      end
      {d, r} = {rdata, rresp};
      rready <= 1'h0;
      if (n == 40) hang();
   endtask : rd_reg
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a, rd, rr);
      chk(rd, e);
   endtask : rchk
   task automatic wait_irq;
      int n;
      repeat (3) @(posedge mclk);
      for (n = 0; n < 600 && irq !== 1'h1; n++) @(posedge mclk);
      if (n == 600) hang();
   endtask : wait_irq
   task automatic cfg(input logic [7:0] c0, c1, input logic [15:0] rl);
      wr(TIC_CTL0_OFF, {24'h0, c0});
      wr(TIC_CTL1_OFF, {24'h0, c1});
      wr(TIC_COUNT_OFF, 32'h1);
      wr(TIC_RELOAD_OFF, {16'h0, rl});
      wr(TIC_PWM_OFF, 32'h0);
      wr(TIC_MASK_OFF, 32'h3);
      rd_reg(TIC_STAT_OFF, rd, rr);
      wr(TIC_CTL0_OFF, {24'h0, c0 | 8'h80});
   endtask : cfg
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rchk(TIC_CTL0_OFF, 32'h0);
      rchk(TIC_COUNT_OFF, 32'h1);
      rchk(TIC_RELOAD_OFF, 32'hFFFF);
      rchk(TIC_PWM_OFF, 32'h0);
      rchk(8'h20, 32'h0);
      chk({30'h0, rr}, {30'h0, TIC_RESP_ERR});
      $display("test reset done");
   endtask : t_reset
   task automatic t_capture;
      logic [31:0] c0, p;
      int a0, p0, off;
      cfg(8'h44, 8'h00, 16'hFFFF);
      rd_reg(TIC_COUNT_OFF, c0, rr);
      a0 = t_ar;
      rd_reg(TIC_COUNT_OFF, rd, rr);
      chk(rd - c0, 32'(t_ar - a0));
      p0 = cyc;
      want <= 1'h1;
      wait_irq();
      rd_reg(TIC_PWM_OFF, p, rr);
      off = int'(p[15:0]) - int'(c0[15:0]) - (p0 - a0);
      chk({31'h0, off > 0 && off < 10}, 32'h1);
      rd_reg(TIC_COUNT_OFF, rd, rr);
      chk({31'h0, rd > p}, 32'h1);
      rchk(TIC_CTL1_OFF, 32'h1);
      rchk(TIC_STAT_OFF, 32'h1);
      repeat (2) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      want <= 1'h0;
      repeat (12) @(posedge mclk);
      rchk(TIC_STAT_OFF, 32'h0);
      rchk(TIC_PWM_OFF, p);
      $display("test capture done");
   endtask : t_capture
   task automatic t_reload;
      cfg(8'h44, 8'h00, 16'h0040);
      want <= 1'h1;
      wait_irq();
      rchk(TIC_STAT_OFF, 32'h1);
      wait_irq();
      rchk(TIC_STAT_OFF, 32'h2);
      rchk(TIC_CTL1_OFF, 32'h0);
      rd_reg(TIC_COUNT_OFF, rd, rr);
      chk({31'h0, rd > 32'h40}, 32'h1);
      cfg(8'h44, 8'h60, 16'h0040);
      repeat (90) @(posedge mclk);
      rchk(TIC_STAT_OFF, 32'h0);
      want <= 1'h0;
      repeat (6) @(posedge mclk);
      want <= 1'h1;
      wait_irq();
      rchk(TIC_STAT_OFF, 32'h1);
      wr(TIC_MASK_OFF, 32'h0);
      want <= 1'h0;
      repeat (6) @(posedge mclk);
      want <= 1'h1;
      repeat (12) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      rchk(TIC_STAT_OFF, 32'h1);
      $display("test reload done");
   endtask : t_reload
   task automatic t_restart;
      logic [31:0] p;
      want <= 1'h0;
      cfg(8'h46, 8'h80, 16'h0100);
      repeat (80) @(posedge mclk);
      want <= 1'h1;
      wait_irq();
      rd_reg(TIC_PWM_OFF, p, rr);
      rd_reg(TIC_COUNT_OFF, rd, rr);
      chk({31'h0, rd < p && p > 32'h40}, 32'h1);
      rchk(TIC_STAT_OFF, 32'h1);
      rchk(TIC_CTL1_OFF, 32'h81);
      wait_irq();
      rchk(TIC_STAT_OFF, 32'h2);
      rchk(TIC_CTL1_OFF, 32'h80);
      rd_reg(TIC_COUNT_OFF, rd, rr);
      chk({31'h0, rd < 32'h40}, 32'h1);
      $display("test restart done");
   endtask : t_restart
   task automatic t_fall;
      cfg(8'h04, 8'h00, 16'h0040);
      wait_irq();
      rchk(TIC_PWM_OFF, 32'h0);
      rchk(TIC_STAT_OFF, 32'h2);
      want <= 1'h0;
      wait_irq();
      rchk(TIC_STAT_OFF, 32'h1);
      rchk(TIC_CTL1_OFF, 32'h1);
      $display("test fall done");
   endtask : t_fall
   task automatic t_pwm;
      int n, hi;
      cfg(8'h4B, 8'h00, 16'h0010);
      wr(TIC_PWM_OFF, 32'h6);
      hi = 0;
      for (n = 0; n < 32; n++) begin
         @(posedge mclk);
         hi += (timer_out === 1'h1);
      end
      chk(32'(hi), 32'hC);
      $display("test pwm done");
   endtask : t_pwm
   // main sequence
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'h0;
      t_reset();
      t_capture();
      t_reload();
      t_restart();
      t_fall();
      t_pwm();
      wrap_up();
   end
endmodule : tb_top
